// [include/eepi_defines.svh]
// eepi_defines.svh: sizes, reset values and timing counts of the eeprom slave
// assumes: included by the package and by the design file, guarded
`ifndef EEPI_DEFINES_SVH
`define EEPI_DEFINES_SVH
`define EEPI_ADDR_W       14
`define EEPI_MEM_BYTES    16384
`define EEPI_PAGE_BYTES   64
`define EEPI_OFF_W        6
`define EEPI_ERASED       8'hff
`define EEPI_PROG_TIME_MS 5
`define EEPI_CLK_KHZ      100000
`define EEPI_FIFO_DEPTH   4
`endif

// [include/eepi_pkg.sv]
// eepi_pkg: types of the eeprom slave
// assumes: eepi_defines.svh on the include path
package eepi_pkg;
`include "eepi_defines.svh"

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wp;
        logic [2:0] cs;
    } eepi_pins_t;

    typedef struct packed {
        logic [`EEPI_ADDR_W-1:0] addr;
        logic [7:0]              data;
    } eepi_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV  = 3'h1,
        ST_AHI  = 3'h2,
        ST_ALO  = 3'h3,
        ST_WR   = 3'h4,
        ST_RD   = 3'h5
    } eepi_st_t;

    typedef struct packed {
        eepi_pins_t                   s1;
        eepi_pins_t                   s2;
        eepi_pins_t                   s3;
        eepi_st_t                     st;
        logic [3:0]                   cnt;
        logic [7:0]                   sh;
        logic [7:0]                   tx;
        logic                         mack;
        logic [`EEPI_ADDR_W-1:0]      addr;
        logic [`EEPI_OFF_W-1:0]       woff;
        logic                         wp_lat;
        logic                         first;
        logic [`EEPI_PAGE_BYTES-1:0]  loaded;
        logic [`EEPI_PAGE_BYTES-1:0][7:0] pbuf;
        logic                         busy;
        logic [`EEPI_OFF_W:0]         cidx;
        logic [19:0]                  tmr;
        logic                         pace;
        logic                         sda_o;
        logic                         sda_oe;
    } eepi_q_t;
endpackage

// [logic/eepi_slave.sv]
// eepi_slave: i2c eeprom slave with page buffer, commit fifo and array
// assumes: scl, sda and straps come from pins; sda wire resolved outside
`timescale 1ns/100ps
`include "eepi_defines.svh"

// ===============================================================
// fifo between commit engine and array
module eepi_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_ff != (AW+1)'(D);
    assign out_valid = cnt_ff != '0;
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_ff[wr_ff] <= in_data;
                wr_ff         <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop)
                rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // eepi_fifo

// ===============================================================
// top: slave protocol, page buffer, program cycle, array
module eepi_slave #(
    parameter logic [3:0] DEV_TYPE = 4'h6, // arbitrary device-type code
    parameter int PROG_CYC = `EEPI_PROG_TIME_MS * `EEPI_CLK_KHZ
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // bus pins
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // straps
    input  wire logic wp,
    input  wire logic chip_select_bit0,
    input  wire logic chip_select_bit1,
    input  wire logic chip_select_bit2,
    // status
    output logic      write_busy
);
    import eepi_pkg::*;

    eepi_q_t    q_ff;
    eepi_q_t    nxt_q;
    eepi_pins_t pins;
    eepi_wr_t   fin;
    eepi_wr_t   fout;
    logic       fin_valid;
    logic       fin_ready;
    logic       fout_valid;
    logic [7:0] rd_byte;
    logic [7:0] mem_ff [`EEPI_MEM_BYTES];

    assign pins    = '{scl: scl, sda: sda_i, wp: wp,
                       cs: {chip_select_bit2, chip_select_bit1, chip_select_bit0}};
    assign rd_byte = mem_ff[q_ff.addr];

    // ===============================================================
    // protocol and commit engine
    always_comb
    begin
        logic scl_r;
        logic scl_f;
        logic start;
        logic stop;
        logic do_load;
        scl_r   = 1'b0;
        scl_f   = 1'b0;
        start   = 1'b0;
        stop    = 1'b0;
        do_load = 1'b0;
        nxt_q    = q_ff;
        nxt_q.s1 = pins;
        nxt_q.s2 = q_ff.s1;
        nxt_q.s3 = q_ff.s2;
        scl_r = q_ff.s2.scl & ~q_ff.s3.scl;
        scl_f = ~q_ff.s2.scl & q_ff.s3.scl;
        start = q_ff.s2.scl & q_ff.s3.scl & q_ff.s3.sda & ~q_ff.s2.sda;
        stop  = q_ff.s2.scl & q_ff.s3.scl & ~q_ff.s3.sda & q_ff.s2.sda;

        // commit: loaded bytes only, one per fifo slot
        fin_valid = q_ff.busy & ~q_ff.cidx[`EEPI_OFF_W]
                    & q_ff.loaded[q_ff.cidx[`EEPI_OFF_W-1:0]];
        fin = '{addr: {q_ff.addr[`EEPI_ADDR_W-1:`EEPI_OFF_W],
                       q_ff.cidx[`EEPI_OFF_W-1:0]},
                data: q_ff.pbuf[q_ff.cidx[`EEPI_OFF_W-1:0]]};
        nxt_q.pace = ~q_ff.pace;
        if (q_ff.busy)
        begin
            if (~q_ff.cidx[`EEPI_OFF_W] & (~fin_valid | fin_ready))
                nxt_q.cidx = q_ff.cidx + 1'b1;
            nxt_q.tmr = q_ff.tmr + 1'b1;
            if (q_ff.tmr >= 20'(PROG_CYC - 1) && q_ff.cidx[`EEPI_OFF_W] && !fout_valid)
            begin
                nxt_q.busy   = 1'b0;
                nxt_q.loaded = '0;
            end
        end

        if (start)
        begin
            nxt_q.st     = ST_DEV;
            nxt_q.cnt    = '0;
            nxt_q.sda_oe = 1'b0;
        end
        else if (stop)
        begin
            if (q_ff.st == ST_WR && |q_ff.loaded && !q_ff.busy)
            begin
                nxt_q.busy = 1'b1;
                nxt_q.cidx = '0;
                nxt_q.tmr  = '0;
            end
            if (q_ff.st == ST_WR)
                nxt_q.addr[`EEPI_OFF_W-1:0] = q_ff.woff;
            nxt_q.st     = ST_IDLE;
            nxt_q.sda_oe = 1'b0;
        end
        else if (q_ff.st != ST_IDLE)
        begin
            if (scl_r)
            begin
                if (q_ff.cnt < 4'h8)
                    nxt_q.sh = {q_ff.sh[6:0], q_ff.s2.sda};
                if (q_ff.cnt == 4'h8)
                    nxt_q.mack = ~q_ff.s2.sda;
                nxt_q.cnt = q_ff.cnt + 1'b1;
            end
            if (scl_f)
            begin
                if (q_ff.st == ST_RD)
                begin
                    if (q_ff.cnt == 4'h8)
                        nxt_q.sda_oe = 1'b0;
                    else if (q_ff.cnt == 4'h9)
                    begin
                        if (q_ff.mack)
                            do_load = 1'b1;
                        else
                        begin
                            nxt_q.st     = ST_IDLE;
                            nxt_q.sda_oe = 1'b0;
                        end
                    end
                    else
                    begin
                        nxt_q.sda_oe = ~q_ff.tx[6];
                        nxt_q.tx     = {q_ff.tx[6:0], 1'b1};
                    end
                end
                else if (q_ff.cnt == 4'h8)
                begin
                    nxt_q.sda_oe = 1'b1;
                    unique case (q_ff.st)
                        ST_DEV:
                        begin
                            if (q_ff.sh[7:4] != DEV_TYPE || q_ff.sh[3:1] != q_ff.s2.cs
                                || q_ff.busy)
                            begin
                                nxt_q.sda_oe = 1'b0;
                                nxt_q.st     = ST_IDLE;
                            end
                        end
                        ST_AHI:
                            nxt_q.addr[`EEPI_ADDR_W-1:8] = q_ff.sh[5:0];
                        ST_ALO:
                        begin
                            nxt_q.addr[7:0] = q_ff.sh;
                            nxt_q.woff      = q_ff.sh[`EEPI_OFF_W-1:0];
                            nxt_q.loaded    = '0;
                            nxt_q.first     = 1'b1;
                        end
                        ST_WR:
                        begin
                            if (q_ff.first && q_ff.wp_lat)
                            begin
                                nxt_q.sda_oe = 1'b0;
                                nxt_q.st     = ST_IDLE;
                            end
                            else
                            begin
                                nxt_q.pbuf[q_ff.woff]   = q_ff.sh;
                                nxt_q.loaded[q_ff.woff] = 1'b1;
                                nxt_q.woff  = q_ff.woff + 1'b1;
                                nxt_q.first = 1'b0;
                            end
                        end
                        default:
                            nxt_q.sda_oe = 1'b0;
                    endcase
                end
                else if (q_ff.cnt == 4'h9)
                begin
                    nxt_q.sda_oe = 1'b0;
                    nxt_q.cnt    = '0;
                    unique case (q_ff.st)
                        ST_DEV:
                        begin
                            if (q_ff.sh[0])
                            begin
                                nxt_q.st = ST_RD;
                                do_load  = 1'b1;
                            end
                            else
                                nxt_q.st = ST_AHI;
                        end
                        ST_AHI:
                            nxt_q.st = ST_ALO;
                        ST_ALO:
                        begin
                            nxt_q.wp_lat = q_ff.s2.wp;
                            nxt_q.st     = ST_WR;
                        end
                        default:
                            nxt_q.st = q_ff.st;
                    endcase
                end
            end
        end

        if (do_load)
        begin
            nxt_q.tx     = rd_byte;
            nxt_q.sda_oe = ~rd_byte[7];
            nxt_q.cnt    = '0;
            nxt_q.addr   = q_ff.addr + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            q_ff <= '{st: ST_IDLE, s1: '1, s2: '1, s3: '1, default: '0};
        else
            q_ff <= nxt_q;
    end

    // ===============================================================
    // fifo and array
    eepi_fifo #(
        .W ($bits(eepi_wr_t)),
        .D (`EEPI_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (fin_valid),
        .in_ready  (fin_ready),
        .in_data   (fin),
        .out_valid (fout_valid),
        .out_ready (q_ff.pace),
        .out_data  (fout)
    );

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < `EEPI_MEM_BYTES; i++)
                mem_ff[i] <= `EEPI_ERASED;
        end
        else if (fout_valid && q_ff.pace)
            mem_ff[fout.addr] <= fout.data;
    end

    assign sda_o      = q_ff.sda_o;
    assign sda_oe     = q_ff.sda_oe;
    assign write_busy = q_ff.busy;

    // ===============================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic scl_fa;
    assign scl_fa = ~q_ff.s2.scl & q_ff.s3.scl;

    busy_released_a: assert property (q_ff.busy |-> !sda_oe)
        else $error("sda driven during program cycle");
    busy_nack_a: assert property (q_ff.busy && q_ff.st == ST_DEV && q_ff.cnt == 4'h8
        && scl_fa |=> !sda_oe && q_ff.st == ST_IDLE)
        else $error("address acked while busy");
    wp_reject_a: assert property (q_ff.st == ST_WR && q_ff.first && q_ff.wp_lat
        && q_ff.cnt == 4'h8 && scl_fa |=> !sda_oe ##1 !q_ff.busy)
        else $error("protected write not rejected");
    wp_no_load_a: assert property ($rose(q_ff.busy) |-> !$past(q_ff.wp_lat))
        else $error("program cycle with protect high");
    addr_only_a: assert property (!q_ff.busy && q_ff.loaded == '0 |=> !q_ff.busy)
        else $error("program cycle without data");
    page_wrap_a: assert property (q_ff.st == ST_WR && $changed(q_ff.woff)
        |-> q_ff.woff == $past(q_ff.woff) + 1'b1
        && q_ff.addr[13:6] == $past(q_ff.addr[13:6]))
        else $error("page offset step wrong");
    read_step_a: assert property (q_ff.st == ST_RD && $changed(q_ff.tx) && q_ff.cnt == '0
        |-> q_ff.addr == $past(q_ff.addr) + 1'b1
        && q_ff.tx == $past(rd_byte))
        else $error("read counter step wrong");
    read_end_a: assert property (q_ff.st == ST_RD && q_ff.cnt == 4'h9 && !q_ff.mack
        && scl_fa |=> q_ff.st == ST_IDLE && !sda_oe)
        else $error("read not ended on nack");
    prog_time_a: assert property (q_ff.busy |-> q_ff.tmr <= 20'(PROG_CYC + 200))
        else $error("program cycle too long");
    data_ack_a: assert property (q_ff.st == ST_WR && !q_ff.first && q_ff.cnt == 4'h8
        && scl_fa |=> sda_oe ##1 q_ff.loaded != '0)
        else $error("data byte not acked");

    cov_page_write_c: cover property ($rose(q_ff.busy));
    cov_seq_read_c: cover property (q_ff.st == ST_RD && q_ff.mack && q_ff.cnt == 4'h9);
    cov_wp_reject_c: cover property (q_ff.st == ST_WR && q_ff.wp_lat && scl_fa);
    cov_fifo_full_c: cover property (q_ff.busy && !fin_ready);
endmodule // eepi_slave

// [sim/eepi_master.sv]
// eepi_master: behavioural bus master for the eeprom slave bench
// assumes: sda resolved by the bench with a pull-up, clock is the system clock
`timescale 1ns/100ps

// ============================================================
// master model
module eepi_master (
    // clock and resolved wire
    input  wire logic clock,
    input  wire logic sda,
    // driven pins
    output logic      scl,
    output logic      sda_pull
);
    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // quarter of a 160 ns bus period
    task automatic half();
        repeat (4) @(negedge clock);
    endtask

    // one clocked bit, line sampled mid high phase
    task automatic bit_x(input logic b, output logic r);
        half();
        sda_pull = !b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        half();
        scl = 1'b0;
    endtask

    // start or repeated start
    task automatic start();
        half();
        sda_pull = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b1;
        half();
        scl = 1'b0;
    endtask

    task automatic stop();
        half();
        sda_pull = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_pull = 1'b0;
    endtask

    // byte out, ninth bit read back
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask

    // byte in, ninth bit is master ack or nack
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(!mack, r);
    endtask
endmodule // eepi_master

// [sim/tb_top.sv]
// tb_top: self-checking bench of the eeprom slave
// assumes: eepi_master drives the bus; short program cycle parameter
`timescale 1ns/100ps
`include "eepi_defines.svh"

// ============================================================
// bench top
module tb_top;
    import eepi_pkg::*;
    localparam logic [3:0] DEV = 4'h6; // arbitrary device-type code
    localparam logic [2:0] CS  = 3'h5;
    logic       clock;
    logic       rst;
    logic       scl;
    logic       m_pull;
    logic       sda;
    logic       sda_o;
    logic       sda_oe;
    logic       wp;
    logic [2:0] cs_pins;
    logic       write_busy;
    int         n_fail;
    int         n_checks;
    logic [7:0] shadow [`EEPI_MEM_BYTES];

    assign sda = !(m_pull || (sda_oe && !sda_o));

    eepi_master u_eepi_master (.clock(clock), .sda(sda), .scl(scl), .sda_pull(m_pull));

    eepi_slave #(.DEV_TYPE(DEV), .PROG_CYC(1000)) u_eepi_slave (
        .clock(clock), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .wp(wp), .chip_select_bit0(cs_pins[0]),
        .chip_select_bit1(cs_pins[1]), .chip_select_bit2(cs_pins[2]),
        .write_busy(write_busy));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ============================================================
    // reporting
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ============================================================
    // bus helpers
    task automatic send_addr(input logic [13:0] a, output logic ack);
        logic k0;
        logic k1;
        u_eepi_master.start();
        u_eepi_master.wbyte({DEV, CS, 1'b0}, k0);
        u_eepi_master.wbyte({2'h3, a[13:8]}, k1);
        u_eepi_master.wbyte(a[7:0], ack);
        check(k0 && k1 && ack, "address bytes acked");
    endtask

    task automatic page_write(input logic [13:0] a, input int n, input logic [7:0] base);
        logic       ack;
        logic [7:0] d;
        send_addr(a, ack);
        for (int k = 0; k < n; k++)
        begin
            d = base + k[7:0];
            u_eepi_master.wbyte(d, ack);
            check(ack === 1'b1, "data acked");
            shadow[{a[13:6], a[5:0] + k[5:0]}] = d;
        end
        u_eepi_master.stop();
    endtask

    task automatic read_seq(input logic [13:0] a, input logic set_addr, input int n);
        logic       ack;
        logic [7:0] d;
        logic [13:0] p;
        if (set_addr)
            send_addr(a, ack);
        u_eepi_master.start();
        u_eepi_master.wbyte({DEV, CS, 1'b1}, ack);
        check(ack === 1'b1, "read address acked");
        for (int k = 0; k < n; k++)
        begin
            p = a + k[13:0];
            u_eepi_master.rbyte(k < n - 1, d);
            check(d === shadow[p], "read data");
        end
        u_eepi_master.stop();
        repeat (8) @(negedge clock);
        check(sda_oe === 1'b0, "released after read");
    endtask

    task automatic poll_ready(input logic busy_exp);
        logic       ack;
        int         i;
        repeat (6) @(negedge clock);
        check(write_busy === busy_exp, "busy after stop");
        if (busy_exp)
        begin
            u_eepi_master.start();
            u_eepi_master.wbyte({DEV, CS, 1'b1}, ack);
            check(ack === 1'b0, "read request during cycle");
            u_eepi_master.stop();
        end
        for (i = 0; i < 40; i++)
        begin
            u_eepi_master.start();
            u_eepi_master.wbyte({DEV, CS, 1'b0}, ack);
            u_eepi_master.stop();
            if (ack)
                break;
        end
        check(ack === 1'b1 && write_busy === 1'b0, "ready after cycle");
        check((i > 0) === busy_exp, "polls nacked while busy");
        if (ack !== 1'b1)
            stop_test();
    endtask

    // ============================================================
    // scenarios
    task automatic sc_reset();
        check(write_busy === 1'b0 && sda_oe === 1'b0, "reset outputs");
        read_seq(14'h1234, 1'b1, 2);
    endtask

    task automatic sc_bad_addr();
        logic ack;
        for (int j = 0; j < 2; j++)
        begin
            u_eepi_master.start();
            u_eepi_master.wbyte(j ? {DEV ^ 4'h1, CS, 1'b0} : {DEV, CS ^ 3'h1, 1'b0}, ack);
            check(ack === 1'b0, "foreign address nacked");
            u_eepi_master.stop();
        end
    endtask

    task automatic sc_page_wrap();
        page_write(14'h013e, 66, 8'h01);
        poll_ready(1'b1);
        read_seq(14'h0100, 1'b1, 64);
    endtask

    task automatic sc_latest_only();
        page_write(14'h0140, 2, 8'h80);
        poll_ready(1'b1);
        read_seq(14'h0140, 1'b1, 64);
    endtask

    task automatic sc_protect();
        logic ack;
        wp = 1'b1;
        send_addr(14'h0105, ack);
        u_eepi_master.wbyte(8'h55, ack);
        check(ack === 1'b0, "protected data nacked");
        u_eepi_master.stop();
        wp = 1'b0;
        poll_ready(1'b0);
        read_seq(14'h0105, 1'b1, 1);
    endtask

    task automatic sc_addr_only();
        logic ack;
        page_write(14'h0000, 1, 8'h3c);
        poll_ready(1'b1);
        send_addr(14'h3fff, ack);
        u_eepi_master.stop();
        repeat (40) @(negedge clock);
        check(write_busy === 1'b0, "no cycle after address only");
        read_seq(14'h3fff, 1'b0, 3);
    endtask

    // ============================================================
    // main sequence and watchdog
    initial
    begin
        n_fail   = 0;
        n_checks = 0;
        rst      = 1'b1;
        wp       = 1'b0;
        cs_pins  = CS;
        foreach (shadow[i])
            shadow[i] = 8'hff;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        sc_reset();
        sc_bad_addr();
        sc_page_wrap();
        sc_latest_only();
        sc_protect();
        sc_addr_only();
        stop_test();
    end

    initial
    begin
        repeat (100000) @(posedge clock);
        n_fail++;
        stop_test();
    end
endmodule // tb_top
